// *** sce_pkg.sv ***
package sce_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned EXEC_TIME_NS     = 500;
  localparam int unsigned EXEC_CYCLES      = (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BUS_RESET_MIN_US = 25;

  // ==========================================================================
  // Command byte layout
  localparam int unsigned CODE_MSB = 7;
  localparam int unsigned CODE_LSB = 4;
  localparam int unsigned INIT_BIT = 3;
  localparam int unsigned TGT_BIT  = 2;
  localparam int unsigned COMMAND_MODIFIER_FLAG  = 1;
  localparam int unsigned INT_BIT  = 0;

  // ==========================================================================
  // Control and data transfer command codes
  localparam logic [3:0] CODE_NOP         = 4'h0;
  localparam logic [3:0] CODE_CLEAR_QUEUE = 4'h1;
  localparam logic [3:0] CODE_RESET_ON    = 4'h2;
  localparam logic [3:0] CODE_RESET_OFF   = 4'h3;
  localparam logic [3:0] CODE_ATN_ON      = 4'h4;
  localparam logic [3:0] CODE_ATN_OFF     = 4'h5;
  localparam logic [3:0] CODE_SEL_ENB     = 4'h6;
  localparam logic [3:0] CODE_SEL_DIS     = 4'h7;
  localparam logic [3:0] CODE_RESEL_ENB   = 4'h8;
  localparam logic [3:0] CODE_RESEL_DIS   = 4'h9;
  localparam logic [3:0] CODE_ADV_ENB     = 4'hA;
  localparam logic [3:0] CODE_ADV_DIS     = 4'hB;
  localparam logic [3:0] CODE_DATA_PTM    = 4'hE;
  localparam logic [3:0] CODE_DATA_MTP    = 4'hF;

  // ==========================================================================
  // Reset values and sizes
  localparam logic        ADV_EN_RST   = 1'b1;
  localparam int unsigned QUEUE_DEPTH  = 4;
  localparam int unsigned SCRIPT_COUNT = 6;
  localparam int unsigned SCRIPT_LEN   = 32;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HANDOFF, ST_DONE} sce_state_t;

endpackage : sce_pkg

// *** sce_link_if.sv ***
`timescale 1ns/10ps
interface sce_link_if #(parameter int PTR_W = 8);
  logic             q_push;
  logic [7:0]       q_data;
  logic             q_full;
  logic             q_pop;
  logic             q_valid;
  logic [7:0]       q_head;
  logic             p_advance;
  logic             p_step;
  logic             p_load;
  logic [PTR_W-1:0] p_load_val;
  logic [PTR_W-1:0] p_ptr;

  modport queue (input q_push, q_data, q_pop, output q_full, q_valid, q_head);
  modport ptr (input p_advance, p_step, p_load, p_load_val, output p_ptr);
  modport exec (output q_push, q_data, q_pop, p_advance, p_step, p_load, p_load_val,
                input q_full, q_valid, q_head, p_ptr);
endinterface : sce_link_if

// *** sce_cmd_queue.sv ***
`timescale 1ns/10ps
module sce_cmd_queue #(
  parameter int DEPTH = 4
) (
  input  wire logic  mclk,
  input  wire logic  rstn,
  sce_link_if.queue  lnk
);
  import sce_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sce_cmd_queue: DEPTH must be a power of two, at least 2");
  end

  logic [7:0]  slot_ff [DEPTH];
  logic [AW-1:0] rd_ff, nxt_rd, wr_ff, nxt_wr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          do_push, do_pop;

  // ==========================================================================
  // Pointers
  always_comb begin
    do_push = lnk.q_push && !lnk.q_full;
    do_pop  = lnk.q_pop && lnk.q_valid;
    nxt_wr  = do_push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = do_pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_ff  <= '0;
      wr_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      rd_ff  <= nxt_rd;
      wr_ff  <= nxt_wr;
      cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================================================
  // Command slots
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    logic [7:0] nxt_slot;
    always_comb begin
      nxt_slot = (do_push && wr_ff == AW'(i)) ? lnk.q_data : slot_ff[i];
    end
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) slot_ff[i] <= 8'h00;
      else       slot_ff[i] <= nxt_slot;
    end
  end

  assign lnk.q_full  = (cnt_ff == (AW+1)'(DEPTH));
  assign lnk.q_valid = (cnt_ff != '0);
  assign lnk.q_head  = slot_ff[rd_ff];
endmodule : sce_cmd_queue

// *** sce_script_ptr.sv ***
`timescale 1ns/10ps
module sce_script_ptr #(
  parameter int COUNT = 6,
  parameter int LEN   = 32
) (
  input  wire logic mclk,
  input  wire logic rstn,
  sce_link_if.ptr   lnk
);
  import sce_pkg::*;
  localparam int IW = $clog2(COUNT);
  localparam int OW = $clog2(LEN);

  if (COUNT < 2 || LEN < 2 || (1 << OW) != LEN) begin : g_chk
    $error("sce_script_ptr: COUNT >= 2 and LEN a power of two >= 2 required");
  end

  logic [IW-1:0] idx_ff, nxt_idx, idx_inc;
  logic [OW-1:0] off_ff, nxt_off;

  // ==========================================================================
  // Pointer update: load, then advance, then contiguous step
  always_comb begin
    idx_inc = (idx_ff == IW'(COUNT - 1)) ? '0 : IW'(idx_ff + 1'b1);
    nxt_idx = idx_ff;
    nxt_off = off_ff;
    if (lnk.p_load) begin
      nxt_idx = lnk.p_load_val[OW +: IW];
      nxt_off = lnk.p_load_val[OW-1:0];
    end else if (lnk.p_advance) begin
      if (off_ff != '0) begin // see [RULE21]
        nxt_idx = idx_inc;
        nxt_off = '0;
      end
    end else if (lnk.p_step) begin
      nxt_off = OW'(off_ff + 1'b1);
      if (off_ff == OW'(LEN - 1)) nxt_idx = idx_inc;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idx_ff <= '0;
      off_ff <= '0;
    end else begin
      idx_ff <= nxt_idx;
      off_ff <= nxt_off;
    end
  end

  assign lnk.p_ptr = {idx_ff, off_ff};
endmodule : sce_script_ptr

// *** sce_control_exec.sv ***
// Summary of operation
// [RULE1] Command byte: code in bits 7-4, role, modifier, interrupt flags; control: roles clear.
// [RULE2] Up to four queued commands are held and executed in order.
// [RULE3] Completion interrupts when the command's flag and the mask bit are set.
// [RULE4] The clear command empties the internal data queue.
// [RULE5] Data queue auto-clears before each data transfer unless disabled by mode bit.
// [RULE6] Bus reset on drives single-ended or differential reset output by mode.
// [RULE7] Bus reset stays asserted until the bus reset release command.
// [RULE8] Firmware spaces reset on and off at least 25 microseconds apart.
// [RULE9] Attention on holds ATN until attention off or last message-out byte.
// [RULE10] Select-with-attention command or sequence raises ATN when selecting.
// [RULE11] Message send with modifier keeps ATN through the last message-out byte.
// [RULE12] Attention off holds ATN low until attention on or select-with-attention.
// [RULE13] Selection enable: respond to selection and set the selection status bit.
// [RULE14] Target await-selection operations see a selection only while enabled.
// [RULE15] Selection disable: ignore SEL, no response, no status bit.
// [RULE16] After reset, selections are ignored until selection enable executes.
// [RULE17] Reselection enable: respond to reselection, set status; off after reset.
// [RULE18] Reselection disable: ignore reselection, no response, no status bit.
// [RULE19] With auto advance, pointer moves to next script at script command start.
// [RULE20] Without auto advance, script accesses stay contiguous.
// [RULE21] A pointer already at location zero of a script is not advanced.
// [RULE22] Control commands ignore soft abort once started and never raise errors.
// [RULE23] Decode code, dispatch action, signal completion before the next command.
`timescale 1ns/10ps
module sce_control_exec #(
  parameter int DEPTH        = sce_pkg::QUEUE_DEPTH,
  parameter int SCRIPT_COUNT = sce_pkg::SCRIPT_COUNT,
  parameter int SCRIPT_LEN   = sce_pkg::SCRIPT_LEN,
  parameter int PTR_W        = $clog2(sce_pkg::SCRIPT_COUNT) + $clog2(sce_pkg::SCRIPT_LEN)
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             cmd_wr,
  input  wire logic [7:0]       cmd_byte,
  output logic                  cmd_ready,
  output logic                  cmd_done,
  input  wire logic             cmd_complete_int_en,
  input  wire logic             int_ack,
  output logic                  irq,
  output logic                  cmd_complete_status,
  input  wire logic             auto_clear_dis,
  input  wire logic             diff_mode,
  input  wire logic             data_xfer_start,
  output logic                  data_queue_clear,
  output logic                  scsi_rst_n_o,
  output logic                  scsi_rst_n_oe,
  output logic                  diff_rst_o,
  output logic                  scsi_atn_n_o,
  output logic                  scsi_atn_n_oe,
  input  wire logic             scsi_sel_n_i,
  input  wire logic             scsi_io_n_i,
  input  wire logic             target_await_selection,
  input  wire logic             initiator_await_reselection,
  output logic                  selection_detect,
  output logic                  reselection_detect,
  output logic                  sel_status,
  input  wire logic             sel_status_clr,
  input  wire logic             select_attention_hit,
  input  wire logic             msg_out_last_byte,
  input  wire logic             command_modifier_flag,
  input  wire logic             script_cmd_start,
  input  wire logic             sequencer_step,
  input  wire logic             script_ptr_load,
  input  wire logic [PTR_W-1:0] script_ptr_wdata,
  output logic [PTR_W-1:0]      script_ptr,
  output logic                  other_cmd_start,
  output logic [7:0]            other_cmd_byte,
  input  wire logic             other_cmd_done
);
  import sce_pkg::*;

  localparam int CW = $clog2(EXEC_CYCLES + 1);
  localparam int PIN_SEL = 0;
  localparam int PIN_IO  = 1;
  localparam int PINS    = 2;

  if (PTR_W != $clog2(SCRIPT_COUNT) + $clog2(SCRIPT_LEN)) begin : g_chk
    $error("sce_control_exec: PTR_W must match script count and length");
  end

  sce_link_if #(.PTR_W(PTR_W)) lnk ();

  sce_cmd_queue #(.DEPTH(DEPTH)) u_queue (
    .mclk (mclk),
    .rstn (rstn),
    .lnk  (lnk.queue)
  );

  sce_script_ptr #(.COUNT(SCRIPT_COUNT), .LEN(SCRIPT_LEN)) u_ptr (
    .mclk (mclk),
    .rstn (rstn),
    .lnk  (lnk.ptr)
  );

  // ==========================================================================
  // Command queue push side
  assign lnk.q_push  = cmd_wr; // see [RULE2]
  assign lnk.q_data  = cmd_byte;
  assign cmd_ready   = !lnk.q_full;

  // ==========================================================================
  // Pin synchronisers
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_stable;

  assign pin_raw[PIN_SEL] = scsi_sel_n_i;
  assign pin_raw[PIN_IO]  = scsi_io_n_i;

  for (genvar k = 0; k < PINS; k++) begin : g_sync
    logic s1_ff, s2_ff, s3_ff, st_ff, nxt_st;
    always_comb begin
      nxt_st = (s2_ff == s3_ff) ? s2_ff : st_ff;
    end
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        s1_ff <= 1'b1;
        s2_ff <= 1'b1;
        s3_ff <= 1'b1;
        st_ff <= 1'b1;
      end else begin
        s1_ff <= pin_raw[k];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        st_ff <= nxt_st;
      end
    end
    assign pin_stable[k] = st_ff;
  end

  // ==========================================================================
  // Executor state
  sce_state_t    state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [7:0]    cur_ff, nxt_cur;
  logic          start_ff, nxt_start;
  logic          done_ff, nxt_done;
  logic [3:0]    head_code;
  logic          head_ctrl;
  logic          take;

  always_comb begin
    head_code = lnk.q_head[CODE_MSB:CODE_LSB];
    head_ctrl = !lnk.q_head[INIT_BIT] && !lnk.q_head[TGT_BIT] // see [RULE1]
                && head_code != CODE_DATA_PTM && head_code != CODE_DATA_MTP;
    take      = (state_ff == ST_IDLE) && lnk.q_valid;
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_cur   = cur_ff;
    nxt_start = 1'b0;
    nxt_done  = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (lnk.q_valid) begin // see [RULE23]
          nxt_cur = lnk.q_head;
          if (head_ctrl) begin
            nxt_state = ST_EXEC;
            nxt_cnt   = CW'(EXEC_CYCLES - 1);
          end else begin
            nxt_state = ST_HANDOFF;
            nxt_start = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        // Runs to the end; no abort and no error exit
        if (cnt_ff == '0) begin // see [RULE22]
          nxt_state = ST_DONE;
          nxt_done  = 1'b1;
        end else begin
          nxt_cnt = CW'(cnt_ff - 1'b1);
        end
      end
      ST_HANDOFF: begin
        if (other_cmd_done) begin
          nxt_state = ST_DONE;
          nxt_done  = 1'b1;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE; // see [RULE23]
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      cur_ff   <= 8'h00;
      start_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      cur_ff   <= nxt_cur;
      start_ff <= nxt_start;
      done_ff  <= nxt_done;
    end
  end

  assign lnk.q_pop       = take; // see [RULE2]
  assign cmd_done        = done_ff;
  assign other_cmd_start = start_ff;
  assign other_cmd_byte  = cur_ff;

  // ==========================================================================
  // Control actions, applied when a command is taken
  logic go;
  logic bus_rst_ff, nxt_bus_rst;
  logic atn_ff, nxt_atn;
  logic sel_en_ff, nxt_sel_en;
  logic resel_en_ff, nxt_resel_en;
  logic adv_en_ff, nxt_adv_en;
  logic dq_clr_ff, nxt_dq_clr;
  logic rst_se_ff, nxt_rst_se;
  logic rst_df_ff, nxt_rst_df;

  always_comb begin
    go           = take && head_ctrl;
    nxt_bus_rst  = bus_rst_ff;
    nxt_atn      = atn_ff;
    nxt_sel_en   = sel_en_ff;
    nxt_resel_en = resel_en_ff;
    nxt_adv_en   = adv_en_ff;
    nxt_dq_clr   = data_xfer_start && !auto_clear_dis; // see [RULE5]
    // Automatic release first, so any set in the same cycle wins
    if (msg_out_last_byte && !command_modifier_flag) nxt_atn = 1'b0; // see [RULE9] [RULE11]
    if (select_attention_hit) nxt_atn = 1'b1; // see [RULE10]
    if (go) begin
      unique case (head_code)
        CODE_CLEAR_QUEUE: nxt_dq_clr   = 1'b1; // see [RULE4]
        CODE_RESET_ON:    nxt_bus_rst  = 1'b1; // see [RULE6]
        CODE_RESET_OFF:   nxt_bus_rst  = 1'b0; // see [RULE7]
        CODE_ATN_ON:      nxt_atn      = 1'b1; // see [RULE9]
        CODE_ATN_OFF:     nxt_atn      = select_attention_hit; // see [RULE12]
        CODE_SEL_ENB:     nxt_sel_en   = 1'b1; // see [RULE13]
        CODE_SEL_DIS:     nxt_sel_en   = 1'b0; // see [RULE15]
        CODE_RESEL_ENB:   nxt_resel_en = 1'b1; // see [RULE17]
        CODE_RESEL_DIS:   nxt_resel_en = 1'b0; // see [RULE18]
        CODE_ADV_ENB:     nxt_adv_en   = 1'b1; // see [RULE19]
        CODE_ADV_DIS:     nxt_adv_en   = 1'b0; // see [RULE20]
        default:          nxt_dq_clr   = nxt_dq_clr;
      endcase
    end
    nxt_rst_se = nxt_bus_rst && !diff_mode; // see [RULE6]
    nxt_rst_df = nxt_bus_rst && diff_mode;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_rst_ff  <= 1'b0;
      atn_ff      <= 1'b0;
      sel_en_ff   <= 1'b0; // see [RULE16]
      resel_en_ff <= 1'b0; // see [RULE17]
      adv_en_ff   <= ADV_EN_RST;
      dq_clr_ff   <= 1'b0;
      rst_se_ff   <= 1'b0;
      rst_df_ff   <= 1'b0;
    end else begin
      bus_rst_ff  <= nxt_bus_rst;
      atn_ff      <= nxt_atn;
      sel_en_ff   <= nxt_sel_en;
      resel_en_ff <= nxt_resel_en;
      adv_en_ff   <= nxt_adv_en;
      dq_clr_ff   <= nxt_dq_clr;
      rst_se_ff   <= nxt_rst_se;
      rst_df_ff   <= nxt_rst_df;
    end
  end

  // Open-drain style RST and ATN outputs drive low while asserted; diff reset and queue clear drive high
  assign scsi_rst_n_o     = 1'b0;
  assign scsi_rst_n_oe    = rst_se_ff;
  assign diff_rst_o       = rst_df_ff;
  assign scsi_atn_n_o     = 1'b0;
  assign scsi_atn_n_oe    = atn_ff;
  assign data_queue_clear = dq_clr_ff;

  // ==========================================================================
  // Selection and reselection detection
  logic sel_lvl, sel_prev_ff, sel_rise;
  logic sel_hit, resel_hit;
  logic sel_det_ff, nxt_sel_det;
  logic resel_det_ff, nxt_resel_det;
  logic sel_st_ff, nxt_sel_st;

  always_comb begin
    sel_lvl       = !pin_stable[PIN_SEL];
    sel_rise      = sel_lvl && !sel_prev_ff;
    sel_hit       = sel_rise && pin_stable[PIN_IO] && sel_en_ff; // see [RULE13] [RULE15]
    resel_hit     = sel_rise && !pin_stable[PIN_IO] && resel_en_ff; // see [RULE17] [RULE18]
    nxt_sel_det   = sel_hit && target_await_selection; // see [RULE14]
    nxt_resel_det = resel_hit && initiator_await_reselection; // see [RULE17]
    nxt_sel_st    = (sel_st_ff && !sel_status_clr) || sel_hit || resel_hit; // see [RULE13]
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_prev_ff  <= 1'b0;
      sel_det_ff   <= 1'b0;
      resel_det_ff <= 1'b0;
      sel_st_ff    <= 1'b0;
    end else begin
      sel_prev_ff  <= sel_lvl;
      sel_det_ff   <= nxt_sel_det;
      resel_det_ff <= nxt_resel_det;
      sel_st_ff    <= nxt_sel_st;
    end
  end

  assign selection_detect   = sel_det_ff;
  assign reselection_detect = resel_det_ff;
  assign sel_status         = sel_st_ff;

  // ==========================================================================
  // Completion status and interrupt
  logic cc_st_ff, nxt_cc_st;

  always_comb begin
    nxt_cc_st = (cc_st_ff && !int_ack) || (done_ff && cur_ff[INT_BIT]); // see [RULE3]
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) cc_st_ff <= 1'b0;
    else       cc_st_ff <= nxt_cc_st;
  end

  assign cmd_complete_status = cc_st_ff;
  assign irq                 = cc_st_ff && cmd_complete_int_en; // see [RULE3]

  // ==========================================================================
  // Script pointer control
  assign lnk.p_advance  = script_cmd_start && adv_en_ff; // see [RULE19] [RULE20]
  assign lnk.p_step     = sequencer_step; // see [RULE20]
  assign lnk.p_load     = script_ptr_load;
  assign lnk.p_load_val = script_ptr_wdata;
  assign script_ptr     = lnk.p_ptr;

endmodule : sce_control_exec

// *** sce_control_exec_asserts.sv ***
`timescale 1ns/10ps
// ============================================================
// Port checker
module sce_control_exec_asserts (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       cmd_done,
  input wire logic       irq,
  input wire logic       cmd_complete_status,
  input wire logic       cmd_complete_int_en,
  input wire logic       int_ack,
  input wire logic       data_queue_clear,
  input wire logic       scsi_rst_n_o,
  input wire logic       scsi_rst_n_oe,
  input wire logic       diff_rst_o,
  input wire logic       scsi_atn_n_o,
  input wire logic       scsi_atn_n_oe,
  input wire logic       select_attention_hit,
  input wire logic       msg_out_last_byte,
  input wire logic       command_modifier_flag,
  input wire logic       sel_status,
  input wire logic       sel_status_clr,
  input wire logic       other_cmd_start,
  input wire logic [7:0] other_cmd_byte
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_irq_mask_gate: assert property (irq == (cmd_complete_status && cmd_complete_int_en))
    else $error("irq differs from status and mask");
  a_status_sticky: assert property (cmd_complete_status && !int_ack |=> cmd_complete_status)
    else $error("completion status lost");
  a_reset_one_pin: assert property (!(scsi_rst_n_oe && diff_rst_o) && !scsi_rst_n_o)
    else $error("both reset outputs driven");
  a_atn_by_select: assert property (select_attention_hit |=> scsi_atn_n_oe)
    else $error("attention not raised by selection");
  a_atn_msg_release: assert property (msg_out_last_byte && !command_modifier_flag
    && !select_attention_hit |=> !scsi_atn_n_oe)
    else $error("attention kept after last message byte");
  a_atn_mod_hold: assert property (scsi_atn_n_oe && msg_out_last_byte
    && command_modifier_flag |=> scsi_atn_n_oe && !scsi_atn_n_o)
    else $error("attention dropped with modifier set");
  a_sel_sticky: assert property (sel_status && !sel_status_clr |=> sel_status)
    else $error("selection status lost");
  a_done_one_cycle: assert property (cmd_done |=> !cmd_done)
    else $error("done longer than one cycle");
  a_clear_one_cycle: assert property (data_queue_clear |=> !data_queue_clear)
    else $error("queue clear longer than one cycle");
  a_handoff_code: assert property (other_cmd_start |-> other_cmd_byte[3:2] != 2'b00
    || other_cmd_byte[7:5] == 3'b111)
    else $error("control command handed off");

  c_irq: cover property (cmd_done ##1 irq);
  c_sel: cover property ($rose(sel_status));
  c_handoff: cover property (other_cmd_start);
endmodule : sce_control_exec_asserts

// *** sce_scsi_peer.sv ***
`timescale 1ns/10ps
// ============================================================
// Far bus device: selects or reselects on request
module sce_scsi_peer (
  input wire logic mclk,
  input wire logic sel_req,
  input wire logic resel,
  output logic     sel_n,
  output logic     io_n
);
  logic [3:0] cnt_ff = 4'h0;
  always @(posedge mclk) begin
    if (sel_req) cnt_ff <= 4'hC;
    else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
  end
  // I/O leads SEL and releases with it; released lines read high
  assign sel_n = !(cnt_ff != 4'h0 && cnt_ff < 4'hA);
  assign io_n  = !(resel && cnt_ff != 4'h0);
endmodule : sce_scsi_peer

// *** sce_control_exec_test.sv ***
`timescale 1ns/10ps
module sce_control_exec_test;
  import sce_pkg::*;
  logic mclk = 0, rstn = 0, cmd_wr = 0, cmd_complete_int_en = 0, auto_clear_dis = 0;
  logic diff_mode = 0, command_modifier_flag = 0, sel_req = 0, resel = 0;
  logic target_await_selection = 0, initiator_await_reselection = 0;
  logic [7:0] cmd_byte = 8'h00, script_ptr_wdata = 8'h00, other_cmd_byte, script_ptr;
  logic [8:0] pls = '0;
  logic cmd_ready, cmd_done, irq, cmd_complete_status, data_queue_clear, scsi_rst_n_o;
  logic scsi_rst_n_oe, diff_rst_o, scsi_atn_n_o, scsi_atn_n_oe, scsi_sel_n_i, scsi_io_n_i;
  logic selection_detect, reselection_detect, sel_status, other_cmd_start;
  wire logic data_xfer_start, select_attention_hit, msg_out_last_byte, script_cmd_start;
  wire logic sequencer_step, script_ptr_load, int_ack, sel_status_clr, other_cmd_done;
  int n_fail = 0, checks_done = 0, n_done = 0, n_clr = 0, n_det = 0;

  assign {other_cmd_done, sel_status_clr, int_ack, script_ptr_load, sequencer_step,
          script_cmd_start, msg_out_last_byte, select_attention_hit, data_xfer_start} = pls;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    n_done += (cmd_done === 1'b1);
    n_clr += (data_queue_clear === 1'b1);
    n_det += (selection_detect === 1'b1) + (reselection_detect === 1'b1);
  end

  sce_control_exec DUT (.*);
  sce_scsi_peer u_peer (.mclk(mclk), .sel_req(sel_req), .resel(resel),
                        .sel_n(scsi_sel_n_i), .io_n(scsi_io_n_i));

  // ============================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic push(input logic [7:0] b);
    @(posedge mclk) begin cmd_wr <= 1'b1; cmd_byte <= b; end
    @(posedge mclk) cmd_wr <= 1'b0;
  endtask : push
  task automatic run_cmd(input logic [3:0] code);
    int i;
    push({code, 4'h0});
    for (i = 0; i < 300 && cmd_done !== 1'b1; i++) @(posedge mclk);
    check(i < 300, 1);
    repeat (2) @(posedge mclk);
  endtask : run_cmd
  task automatic pulse(input int i);
    @(posedge mclk) pls[i] <= 1'b1;
    @(posedge mclk) pls <= '0;
    repeat (3) @(posedge mclk);
  endtask : pulse
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // ============================================================
  // Scenarios
  task automatic t_reset;
    check(cmd_ready, 1);
    check({scsi_rst_n_oe, diff_rst_o, scsi_atn_n_oe, sel_status, script_ptr}, 0);
    $display("test reset finished");
  endtask : t_reset
  task automatic t_bus_reset;
    for (int d = 0; d < 2; d++) begin
      @(posedge mclk) diff_mode <= d[0];
      run_cmd(CODE_RESET_ON);
      check({scsi_rst_n_oe, diff_rst_o}, d[0] ? 2'b01 : 2'b10);
      repeat (2500) @(posedge mclk);
      check({scsi_rst_n_oe, diff_rst_o}, d[0] ? 2'b01 : 2'b10);
      run_cmd(CODE_RESET_OFF);
      check({scsi_rst_n_oe, diff_rst_o}, 0);
    end
    $display("test bus reset finished");
  endtask : t_bus_reset
  task automatic t_atn;
    run_cmd(CODE_ATN_ON);
    check({scsi_atn_n_oe, scsi_atn_n_o}, 2'b10);
    @(posedge mclk) command_modifier_flag <= 1'b1;
    pulse(2);
    check(scsi_atn_n_oe, 1);
    @(posedge mclk) command_modifier_flag <= 1'b0;
    pulse(2);
    check(scsi_atn_n_oe, 0);
    pulse(1);
    check(scsi_atn_n_oe, 1);
    run_cmd(CODE_ATN_OFF);
    check(scsi_atn_n_oe, 0);
    $display("test attention finished");
  endtask : t_atn
  task automatic sel_case(input logic [3:0] code, input logic rs, input logic exp);
    run_cmd(code);
    pulse(7);
    n_det = 0;
    @(posedge mclk) begin
      resel <= rs;
      target_await_selection <= !rs;
      initiator_await_reselection <= rs;
      sel_req <= 1'b1;
    end
    @(posedge mclk) sel_req <= 1'b0;
    repeat (25) @(posedge mclk);
    check(sel_status, exp);
    check(n_det, exp);
  endtask : sel_case
  task automatic t_select;
    sel_case(CODE_NOP, 0, 0);
    sel_case(CODE_SEL_ENB, 0, 1);
    sel_case(CODE_SEL_DIS, 0, 0);
    sel_case(CODE_NOP, 1, 0);
    sel_case(CODE_RESEL_ENB, 1, 1);
    sel_case(CODE_RESEL_DIS, 1, 0);
    $display("test selection finished");
  endtask : t_select
  task automatic t_queue;
    @(posedge mclk) cmd_complete_int_en <= 1'b1;
    n_done = 0;
    for (int i = 0; i < 6; i++) @(posedge mclk) begin
      cmd_wr <= 1'b1;
      cmd_byte <= (i == 4) ? 8'h01 : 8'h00;
    end
    @(posedge mclk) cmd_wr <= 1'b0;
    #1 check(cmd_ready, 0);
    repeat (400) @(posedge mclk);
    check(n_done, 5);
    check({irq, cmd_complete_status}, 2'b11);
    pulse(6);
    check({irq, cmd_complete_status}, 0);
    @(posedge mclk) cmd_complete_int_en <= 1'b0;
    push(8'h01);
    repeat (80) @(posedge mclk);
    check({irq, cmd_complete_status}, 2'b01);
    $display("test queue finished");
  endtask : t_queue
  task automatic t_clear;
    n_clr = 0;
    pulse(0);
    check(n_clr, 1);
    @(posedge mclk) auto_clear_dis <= 1'b1;
    pulse(0);
    check(n_clr, 1);
    run_cmd(CODE_CLEAR_QUEUE);
    check(n_clr, 2);
    $display("test clear finished");
  endtask : t_clear
  task automatic ld(input logic [7:0] v);
    @(posedge mclk) script_ptr_wdata <= v;
    pulse(5);
  endtask : ld
  task automatic t_ptr;
    ld(8'h23);
    pulse(3);
    check(script_ptr, 8'h40);
    pulse(3);
    check(script_ptr, 8'h40);
    pulse(4);
    run_cmd(CODE_ADV_DIS);
    pulse(3);
    check(script_ptr, 8'h41);
    run_cmd(CODE_ADV_ENB);
    ld(8'hA5);
    pulse(3);
    check(script_ptr, 8'h00);
    $display("test pointer finished");
  endtask : t_ptr
  task automatic t_handoff;
    logic [7:0] bs [2] = '{8'h38, 8'hE0};
    foreach (bs[k]) begin
      n_done = 0;
      push(bs[k]);
      repeat (2) @(posedge mclk);
      check(other_cmd_start, 1);
      repeat (3) @(posedge mclk);
      check({other_cmd_byte, n_done[0]}, {bs[k], 1'b0});
      pulse(8);
      check(n_done, 1);
    end
    $display("test handoff finished");
  endtask : t_handoff

  // ============================================================
  // Sequence and watchdog
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_select();
    t_bus_reset();
    t_atn();
    t_queue();
    t_clear();
    t_ptr();
    t_handoff();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    wrap_up();
  end
endmodule : sce_control_exec_test

bind sce_control_exec sce_control_exec_asserts u_chk (.*);
